//--- core/fll_clock_synth_control.sv
`timescale 1ns/10ps
module fll_clock_synth_control #(
  parameter int ERR_W = 16
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET,
  input  wire logic                 CE,
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic      [31:0]          PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  input  wire logic                 MASTER_CLK,
  input  wire logic                 BIT_CLK,
  input  wire logic                 FRAME_CLK,
  input  wire logic                 OSC_TICK,
  input  wire logic signed [ERR_W-1:0] LOOP_ERROR,
  output logic                      OSC_RUN,
  output logic                      LOOP_RUN,
  output logic                      FRACTIONAL_MODE,
  output logic                      REF_TICK,
  output logic                      CONTROL_TICK,
  output logic                      LOOP_OUTPUT_CLOCK,
  output logic      [29:0]          TARGET_RATIO,
  output logic signed [ERR_W+7:0]   SCALED_ERROR
);

  // register state
  logic [2:0]  enable_reg,    enable_next;
  logic [5:0]  outdiv_reg,    outdiv_next;
  logic [2:0]  rate_reg,      rate_next;
  logic [2:0]  fratio_reg,    fratio_next;
  logic [15:0] fraction_reg,  fraction_next;
  logic [9:0]  intmult_reg,   intmult_next;
  logic [3:0]  gain_reg,      gain_next;
  logic [1:0]  refdiv_reg,    refdiv_next;
  logic [1:0]  refsrc_reg,    refsrc_next;
  logic [31:0] rdata_reg,     rdata_next;
  // datapath state
  logic        ref_prev_reg,  ref_prev_next;
  logic [2:0]  ref_cnt_reg,   ref_cnt_next;
  logic        ref_tick_reg,  ref_tick_next;
  logic [2:0]  rate_cnt_reg,  rate_cnt_next;
  logic        ctrl_tick_reg, ctrl_tick_next;
  logic [5:0]  out_cnt_reg,   out_cnt_next;
  logic        out_clk_reg,   out_clk_next;
  logic [29:0] target_reg,    target_next;
  logic signed [ERR_W+7:0] err_reg, err_next;

  logic [7:0]  index;
  logic        mapped;
  logic        wr_en;
  logic        ref_level;
  logic        ref_rise;
  logic [2:0]  ref_limit;
  logic [4:0]  ratio_value;
  logic [3:0]  gain_eff;
  logic        osc_on;
  logic        reserved_seen;
  logic [4:0]  status_word;

  // address decode
  assign index  = PADDR[9:2];
  assign mapped = (PADDR[1:0] == 2'h0) && (PADDR[11:10] == 2'h0) &&
                  ((index >= fll_ctrl_pkg::IDX_ENABLE_CTRL &&
                    index <= fll_ctrl_pkg::IDX_REF_SELECT) ||
                   index == fll_ctrl_pkg::IDX_LOOP_STATUS);
  assign wr_en  = CE && PSEL && PENABLE && PWRITE && mapped;

  // bus handshake; registered read data
  assign PREADY  = CE;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA  = rdata_reg;

  // oscillator needed by free-running or locked loop
  assign osc_on = enable_reg[fll_ctrl_pkg::POS_OSC_ENABLE] ||
                  enable_reg[fll_ctrl_pkg::POS_LOOP_ENABLE];
  // reserved output divider or reference code in use
  assign reserved_seen = (outdiv_reg < fll_ctrl_pkg::OUTDIV_MIN_CODE) ||
                         (refsrc_reg == fll_ctrl_pkg::SRC_NONE);

  // status word for software
  assign status_word = {reserved_seen, out_clk_reg, ref_level, LOOP_RUN, osc_on};

  // register writes
  always_comb begin
    enable_next   = enable_reg;
    outdiv_next   = outdiv_reg;
    rate_next     = rate_reg;
    fratio_next   = fratio_reg;
    fraction_next = fraction_reg;
    intmult_next  = intmult_reg;
    gain_next     = gain_reg;
    refdiv_next   = refdiv_reg;
    refsrc_next   = refsrc_reg;
    if (wr_en) begin
      if (index == fll_ctrl_pkg::IDX_ENABLE_CTRL) begin
        enable_next = PWDATA[2:0];
      end else if (index == fll_ctrl_pkg::IDX_DIVIDER_CTRL) begin
        outdiv_next = PWDATA[fll_ctrl_pkg::POS_OUTDIV_LSB +: 6];
        rate_next   = PWDATA[fll_ctrl_pkg::POS_CTRL_RATE_LSB +: 3];
        fratio_next = PWDATA[fll_ctrl_pkg::POS_FRATIO_LSB +: 3];
      end else if (index == fll_ctrl_pkg::IDX_FRACTION_MULT) begin
        fraction_next = PWDATA[15:0];
      end else if (index == fll_ctrl_pkg::IDX_INTEGER_GAIN) begin
        intmult_next = PWDATA[fll_ctrl_pkg::POS_INT_MULT_LSB +: 10];
        gain_next    = PWDATA[fll_ctrl_pkg::POS_GAIN_LSB +: 4];
      end else if (index == fll_ctrl_pkg::IDX_REF_SELECT) begin
        refdiv_next = PWDATA[fll_ctrl_pkg::POS_REF_DIV_LSB +: 2];
        refsrc_next = PWDATA[fll_ctrl_pkg::POS_REF_SRC_LSB +: 2];
      end
    end
  end

  // read capture in the setup cycle
  always_comb begin
    rdata_next = rdata_reg;
    if (CE && PSEL && !PENABLE) begin
      rdata_next = 32'h0000_0000;
      if (index == fll_ctrl_pkg::IDX_ENABLE_CTRL) begin
        rdata_next[2:0] = enable_reg;
      end else if (index == fll_ctrl_pkg::IDX_DIVIDER_CTRL) begin
        rdata_next[fll_ctrl_pkg::POS_OUTDIV_LSB +: 6]    = outdiv_reg;
        rdata_next[fll_ctrl_pkg::POS_CTRL_RATE_LSB +: 3] = rate_reg;
        rdata_next[fll_ctrl_pkg::POS_FRATIO_LSB +: 3]    = fratio_reg;
      end else if (index == fll_ctrl_pkg::IDX_FRACTION_MULT) begin
        rdata_next[15:0] = fraction_reg;
      end else if (index == fll_ctrl_pkg::IDX_INTEGER_GAIN) begin
        rdata_next[fll_ctrl_pkg::POS_INT_MULT_LSB +: 10] = intmult_reg;
        rdata_next[fll_ctrl_pkg::POS_GAIN_LSB +: 4]      = gain_reg;
      end else if (index == fll_ctrl_pkg::IDX_REF_SELECT) begin
        rdata_next[fll_ctrl_pkg::POS_REF_DIV_LSB +: 2] = refdiv_reg;
        rdata_next[fll_ctrl_pkg::POS_REF_SRC_LSB +: 2] = refsrc_reg;
      end else if (index == fll_ctrl_pkg::IDX_LOOP_STATUS) begin
        rdata_next[4:0] = status_word;
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      enable_reg   <= fll_ctrl_pkg::RST_ENABLE_CTRL;
      outdiv_reg   <= fll_ctrl_pkg::RST_OUTDIV;
      rate_reg     <= fll_ctrl_pkg::RST_CTRL_RATE;
      fratio_reg   <= fll_ctrl_pkg::RST_FRATIO;
      fraction_reg <= fll_ctrl_pkg::RST_FRACTION;
      intmult_reg  <= fll_ctrl_pkg::RST_INT_MULT;
      gain_reg     <= fll_ctrl_pkg::RST_GAIN;
      refdiv_reg   <= fll_ctrl_pkg::RST_REF_DIV;
      refsrc_reg   <= fll_ctrl_pkg::RST_REF_SRC;
    end else if (CE) begin
      enable_reg   <= enable_next;
      outdiv_reg   <= outdiv_next;
      rate_reg     <= rate_next;
      fratio_reg   <= fratio_next;
      fraction_reg <= fraction_next;
      intmult_reg  <= intmult_next;
      gain_reg     <= gain_next;
      refdiv_reg   <= refdiv_next;
      refsrc_reg   <= refsrc_next;
    end
  end

  // read data register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CE) begin
      rdata_reg <= rdata_next;
    end
  end

  // reference mux, edge detect and pre-divider
  always_comb begin
    case (refsrc_reg)
      fll_ctrl_pkg::SRC_MASTER: ref_level = MASTER_CLK;
      fll_ctrl_pkg::SRC_BIT:    ref_level = BIT_CLK;
      fll_ctrl_pkg::SRC_FRAME:  ref_level = FRAME_CLK;
      default:                  ref_level = 1'b0;                     // reserved: no reference
    endcase
    ref_rise      = ref_level && !ref_prev_reg;
    ref_limit     = 3'((4'h1 << refdiv_reg) - 4'h1);
    ref_prev_next = ref_level;
    ref_cnt_next  = ref_cnt_reg;
    ref_tick_next = 1'b0;
    if (!LOOP_RUN) begin
      ref_cnt_next = 3'h0;
    end else if (ref_rise) begin
      if (ref_cnt_reg >= ref_limit) begin
        ref_cnt_next  = 3'h0;
        ref_tick_next = 1'b1;
      end else begin
        ref_cnt_next = ref_cnt_reg + 3'h1;
      end
    end
  end

  // oscillator-side dividers: control rate and output clock
  always_comb begin
    rate_cnt_next  = rate_cnt_reg;
    ctrl_tick_next = 1'b0;
    out_cnt_next   = out_cnt_reg;
    out_clk_next   = 1'b0;
    if (!osc_on) begin
      rate_cnt_next = 3'h0;
      out_cnt_next  = 6'h00;
    end else if (OSC_TICK) begin
      if (rate_cnt_reg >= rate_reg) begin
        rate_cnt_next  = 3'h0;
        ctrl_tick_next = 1'b1;
      end else begin
        rate_cnt_next = rate_cnt_reg + 3'h1;
      end
      if (outdiv_reg < fll_ctrl_pkg::OUTDIV_MIN_CODE) begin
        out_cnt_next = 6'h00;                                         // reserved codes stall
      end else if (out_cnt_reg >= outdiv_reg) begin
        out_cnt_next = 6'h00;
        out_clk_next = 1'b1;
      end else begin
        out_cnt_next = out_cnt_reg + 6'h01;
      end
    end
  end

  // target ratio and scaled loop error
  always_comb begin
    ratio_value = fratio_reg[2] ? 5'h10 : 5'(5'h1 << fratio_reg[1:0]);
    target_next = 30'({4'h0, intmult_reg, fraction_reg}) * 30'(ratio_value);
    gain_eff    = (gain_reg > fll_ctrl_pkg::GAIN_MAX_CODE) ?
                  fll_ctrl_pkg::GAIN_MAX_CODE : gain_reg;
    err_next    = err_reg;
    if (!LOOP_RUN) begin
      err_next = '0;
    end else if (ctrl_tick_reg) begin
      err_next = (ERR_W+8)'(LOOP_ERROR) <<< gain_eff;
    end
  end

  // reference state registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ref_prev_reg  <= 1'b0;
      ref_cnt_reg   <= 3'h0;
      ref_tick_reg  <= 1'b0;
    end else if (CE) begin
      ref_prev_reg  <= ref_prev_next;
      ref_cnt_reg   <= ref_cnt_next;
      ref_tick_reg  <= ref_tick_next;
    end
  end

  // oscillator-side registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      rate_cnt_reg  <= 3'h0;
      ctrl_tick_reg <= 1'b0;
      out_cnt_reg   <= 6'h00;
      out_clk_reg   <= 1'b0;
    end else if (CE) begin
      rate_cnt_reg  <= rate_cnt_next;
      ctrl_tick_reg <= ctrl_tick_next;
      out_cnt_reg   <= out_cnt_next;
      out_clk_reg   <= out_clk_next;
    end
  end

  // target and error registers
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      target_reg    <= 30'h0000_0000;
      err_reg       <= '0;
    end else if (CE) begin
      target_reg    <= target_next;
      err_reg       <= err_next;
    end
  end

  // analog-side controls
  assign OSC_RUN           = osc_on;
  assign LOOP_RUN          = enable_reg[fll_ctrl_pkg::POS_LOOP_ENABLE];
  assign FRACTIONAL_MODE   = enable_reg[fll_ctrl_pkg::POS_FRAC_ENABLE];
  assign REF_TICK          = ref_tick_reg;
  assign CONTROL_TICK      = ctrl_tick_reg;
  assign LOOP_OUTPUT_CLOCK = out_clk_reg;
  assign TARGET_RATIO      = target_reg;
  assign SCALED_ERROR      = err_reg;

endmodule : fll_clock_synth_control

//--- inc/fll_ctrl_pkg.sv
package fll_ctrl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_ENABLE_CTRL   = 8'h74;
  localparam logic [7:0]  IDX_DIVIDER_CTRL  = 8'h75;
  localparam logic [7:0]  IDX_FRACTION_MULT = 8'h76;
  localparam logic [7:0]  IDX_INTEGER_GAIN  = 8'h77;
  localparam logic [7:0]  IDX_REF_SELECT    = 8'h78;
  localparam logic [7:0]  IDX_LOOP_STATUS   = 8'h7B;
  // enable control fields
  localparam int          POS_LOOP_ENABLE   = 0;
  localparam int          POS_OSC_ENABLE    = 1;
  localparam int          POS_FRAC_ENABLE   = 2;
  // divider control fields
  localparam int          POS_OUTDIV_LSB    = 8;
  localparam int          POS_CTRL_RATE_LSB = 4;
  localparam int          POS_FRATIO_LSB    = 0;
  localparam logic [5:0]  OUTDIV_MIN_CODE   = 6'h03;
  // integer multiplier and gain fields
  localparam int          POS_INT_MULT_LSB  = 5;
  localparam int          POS_GAIN_LSB      = 0;
  localparam logic [3:0]  GAIN_MAX_CODE     = 4'h8;
  // reference select fields
  localparam int          POS_REF_DIV_LSB   = 3;
  localparam int          POS_REF_SRC_LSB   = 0;
  // reset values
  localparam logic [2:0]  RST_ENABLE_CTRL   = 3'h0;
  localparam logic [5:0]  RST_OUTDIV        = 6'h00;
  localparam logic [2:0]  RST_CTRL_RATE     = 3'h0;
  localparam logic [2:0]  RST_FRATIO        = 3'h7;
  localparam logic [15:0] RST_FRACTION      = 16'h0000;
  localparam logic [9:0]  RST_INT_MULT      = 10'h007;
  localparam logic [3:0]  RST_GAIN          = 4'h0;
  localparam logic [1:0]  RST_REF_DIV       = 2'h0;
  localparam logic [1:0]  RST_REF_SRC       = 2'h0;
  // reference source codes
  typedef enum logic [1:0] {
    SRC_MASTER = 2'h0,
    SRC_BIT    = 2'h1,
    SRC_FRAME  = 2'h2,
    SRC_NONE   = 2'h3
  } ref_source_t;
endpackage : fll_ctrl_pkg

//--- tb/fll_clock_synth_control_assertions.sv
`timescale 1ns/10ps
module fll_clock_synth_control_assertions #(
  parameter int ERR_W = 16
) (
  input wire logic                    CLK_SYS,
  input wire logic                    RESET,
  input wire logic                    CE,
  input wire logic                    PSEL,
  input wire logic                    PENABLE,
  input wire logic                    PWRITE,
  input wire logic                    OSC_TICK,
  input wire logic                    OSC_RUN,
  input wire logic                    LOOP_RUN,
  input wire logic                    FRACTIONAL_MODE,
  input wire logic                    REF_TICK,
  input wire logic                    CONTROL_TICK,
  input wire logic                    LOOP_OUTPUT_CLOCK,
  input wire logic [29:0]             TARGET_RATIO,
  input wire logic signed [ERR_W+7:0] SCALED_ERROR
);
  // a register write taken at this edge
  wire logic bus_write = PSEL && PENABLE && PWRITE && CE;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // loop needs the oscillator; enable and mode bits move only on writes
  a_locked_osc_runs: assert property (LOOP_RUN |-> OSC_RUN)
    else $error("loop running without oscillator");
  a_loop_on_write: assert property ($rose(LOOP_RUN) |-> $past(bus_write))
    else $error("loop started without a write");
  a_frac_on_write: assert property ($changed(FRACTIONAL_MODE) |-> $past(bus_write))
    else $error("mode changed without a write");
  // control and output pulses need a counting oscillator tick; reference ticks need the loop on
  a_ctrl_tick_cause: assert property (CONTROL_TICK && $past(CE) |-> $past(OSC_TICK && OSC_RUN))
    else $error("control tick without oscillator tick");
  a_out_tick_cause: assert property (LOOP_OUTPUT_CLOCK && $past(CE) |-> $past(OSC_TICK && OSC_RUN))
    else $error("output pulse without oscillator tick");
  a_ref_tick_gated: assert property (REF_TICK && $past(CE) |-> $past(LOOP_RUN))
    else $error("reference tick while loop off");
  // datapath outputs follow their causes
  a_scaled_on_tick: assert property ($changed(SCALED_ERROR) |->
    $past(CONTROL_TICK) || $past(!LOOP_RUN))
    else $error("scaled error moved without control tick");
  a_ratio_on_write: assert property ($changed(TARGET_RATIO) |->
    $past(bus_write) || $past(bus_write, 2) || $past(RESET) || $past(RESET, 2))
    else $error("target ratio moved without a write");
  c_out_pulse: cover property (LOOP_OUTPUT_CLOCK);
  c_ref_tick: cover property (REF_TICK);
  c_ctrl_run: cover property (CONTROL_TICK ##1 CONTROL_TICK);
endmodule : fll_clock_synth_control_assertions

bind fll_clock_synth_control fll_clock_synth_control_assertions #(.ERR_W(ERR_W)) u_chk (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .OSC_TICK(OSC_TICK), .OSC_RUN(OSC_RUN), .LOOP_RUN(LOOP_RUN),
  .FRACTIONAL_MODE(FRACTIONAL_MODE), .REF_TICK(REF_TICK), .CONTROL_TICK(CONTROL_TICK),
  .LOOP_OUTPUT_CLOCK(LOOP_OUTPUT_CLOCK), .TARGET_RATIO(TARGET_RATIO),
  .SCALED_ERROR(SCALED_ERROR));

//--- tb/fll_clock_synth_control_test.sv
`timescale 1ns/10ps
module fll_clock_synth_control_test;
  logic               clk_sys, reset, ce, psel, penable, pwrite, osc_tick, mclk, bclk, fclk;
  logic               pready, pslverr, err, osc_run, loop_run, frac_mode, ref_tick, ctl_tick;
  logic               out_clk;
  logic        [11:0] paddr;
  logic        [31:0] pwdata, prdata, rd;
  logic        [29:0] ratio;
  logic signed [15:0] loop_err;
  logic signed [23:0] scaled;
  int                 n_mismatch, samples_checked, cyc;
  fll_clock_synth_control u_fll_clock_synth_control (
    .CLK_SYS(clk_sys), .RESET(reset), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MASTER_CLK(mclk), .BIT_CLK(bclk), .FRAME_CLK(fclk),
    .OSC_TICK(osc_tick), .LOOP_ERROR(loop_err), .OSC_RUN(osc_run), .LOOP_RUN(loop_run),
    .FRACTIONAL_MODE(frac_mode), .REF_TICK(ref_tick), .CONTROL_TICK(ctl_tick),
    .LOOP_OUTPUT_CLOCK(out_clk), .TARGET_RATIO(ratio), .SCALED_ERROR(scaled));
  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer, held until ready is seen
  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset_regs;
    repeat (2) @(posedge clk_sys);
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(pready, 0);
    ce <= 1'b1;
    apb(8'h75, 0, 0);
    chk(rd, 32'h0000_0007);
    apb(8'h77, 0, 0);
    chk(rd, 32'h0000_00E0);
    chk(ratio, 32'h0070_0000);
    apb(8'h00, 0, 0);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
  endtask : t_reset_regs
  task automatic t_access;
    logic [31:0] mask [5] = '{32'h7, 32'h3F77, 32'hFFFF, 32'h7FEF, 32'h1B};
    for (int i = 0; i < 5; i++) begin
      apb(8'h74 + 8'(i), 1, 32'hFFFF_FFFF);
      apb(8'h74 + 8'(i), 0, 0);
      chk(rd, mask[i]);
      apb(8'h74 + 8'(i), 1, 0);
    end
  endtask : t_access
  task automatic t_enable;
    logic [2:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 3'(i);
      apb(8'h74, 1, 32'(i));
      @(negedge clk_sys);
      chk({osc_run, loop_run, frac_mode}, {v[1] | v[0], v[0], v[2]});
      apb(8'h7B, 0, 0);
      chk(rd, {27'h0, 1'b1, 2'h0, v[0], v[1] | v[0]});
    end
  endtask : t_enable
  task automatic t_ratio;
    apb(8'h77, 1, 32'h60);
    apb(8'h76, 1, 32'h8000);
    for (int c = 0; c < 8; c++) begin
      apb(8'h75, 1, 32'(c));
      repeat (3) @(posedge clk_sys);
      chk(ratio, 32'h38000 << (c > 3 ? 4 : c));
    end
  endtask : t_ratio
  // spacing of control ticks or output pulses with the oscillator ticking every cycle
  task automatic gap(input bit sel, input logic [5:0] od, input logic [2:0] rt, input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    apb(8'h74, 1, 32'h2);
    apb(8'h75, 1, {18'h0, od, 1'b0, rt, 4'h0});
    osc_tick <= 1'b1;
    repeat (140) begin
      @(negedge clk_sys);
      if ((sel ? out_clk : ctl_tick) === 1'b1) k++;
      if (k == 1) n++;
    end
    @(posedge clk_sys);
    osc_tick <= 1'b0;
    chk(exp == 0 ? k : n, exp);
  endtask : gap
  task automatic t_osc;
    gap(1, 6'h03, 3'h0, 4);
    gap(1, 6'h3F, 3'h0, 64);
    gap(1, 6'h02, 3'h0, 0);
    gap(0, 6'h00, 3'h0, 1);
    gap(0, 6'h00, 3'h7, 8);
  endtask : t_osc
  task automatic t_gain;
    apb(8'h75, 1, 32'h0);
    apb(8'h74, 1, 32'h3);
    osc_tick <= 1'b1;
    loop_err <= -16'sd3;
    for (int g = 0; g < 16; g += 4) begin
      apb(8'h77, 1, 32'(g));
      repeat (4) @(posedge clk_sys);
      chk(32'(scaled), 32'(-3 * (1 << (g > 8 ? 8 : g))));
    end
    osc_tick <= 1'b0;
  endtask : t_gain
  task automatic t_ref;
    int k;
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        k = 0;
        apb(8'h74, 1, 32'h0);
        apb(8'h78, 1, 32'((d << 3) | s));
        apb(8'h74, 1, 32'h2);
        apb(8'h74, 1, 32'h3);
        for (int i = 0; i < 260; i++) begin
          @(posedge clk_sys);
          mclk <= s == 0 && i < 256 && i[3];
          bclk <= s == 1 && i < 256 && i[3];
          fclk <= s == 2 && i < 256 && i[3];
          @(negedge clk_sys);
          if (ref_tick === 1'b1) k++;
        end
        chk(k, s == 3 ? 0 : 16 >> d);
      end
    end
  endtask : t_ref
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    {psel, penable, pwrite, osc_tick, mclk, bclk, fclk, paddr, pwdata, loop_err} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_regs();
    t_access();
    t_enable();
    t_ratio();
    t_osc();
    t_gain();
    t_ref();
    tally_and_finish();
  end
endmodule : fll_clock_synth_control_test
